// ==== rtl/usf_top.sv ====
/*
  usf_top: serial port done flags, extra receive bit, interrupt and
  APB register slave.
  Assumes the receive/transmit core runs on pclk and reports frames and
  stop-bit starts as one-cycle pulses; the receive FIFO reports a level.
*/
`timescale 1ns/1ns
module usf_top
  import usf_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [USF_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // receive/transmit core
  input  wire usf_rx_evt_s       rx_evt,
  input  wire logic              tx_stop_start,
  input  wire logic              rx_fifo_pending,
  output logic                   extra_bit_enable,
  output logic                   multiproc_enable,
  output logic                   parity_enable,
  // interrupt
  output logic                   irq
);

  usf_apb_e                st_r;
  usf_apb_e                st_nxt;
  usf_ctrl_s               ctrl_r;
  logic [USF_EVT_W-1:0]    mask_r;
  logic [USF_EVT_W-1:0]    evt_q;
  logic                    extra_rx_bit_r;
  logic                    rx_done_q;
  logic                    tx_done_q;
  logic                    irq_r;
  logic [31:0]             prdata_r;
  logic                    pready_r;
  logic                    pslverr_r;

  // bus decode
  wire acc       = psel & penable;
  wire commit    = acc & pready_r;
  wire wr        = commit & pwrite;
  wire sel_ctrl  = (paddr == USF_OFS_CTRL);
  wire sel_flags = (paddr == USF_OFS_FLAGS);
  wire sel_evt   = (paddr == USF_OFS_EVT);
  wire sel_mask  = (paddr == USF_OFS_MASK);
  wire hit       = sel_ctrl | sel_flags | sel_evt | sel_mask;
  wire wr_ctrl   = wr & sel_ctrl;
  wire wr_flags  = wr & sel_flags;
  wire wr_evt    = wr & sel_evt;
  wire wr_mask   = wr & sel_mask;

  // frame qualification
  wire rx_accept = rx_evt.valid & rx_evt.stop_bit & (~ctrl_r.multiproc_enable | rx_evt.extra_bit); // R7 R10
  wire rx_reject = rx_evt.valid & ~rx_accept;
  wire xrb_nxt   = ctrl_r.extra_bit_enable ? rx_evt.extra_bit : rx_evt.stop_bit; // R1 R2

  // software clears a done flag by writing zero to it
  wire rx_clr = wr_flags & ~pwdata[USF_FLG_RX];
  wire tx_clr = wr_flags & ~pwdata[USF_FLG_TX];

  wire [USF_EVT_W-1:0] evt_set = {rx_reject, tx_stop_start, rx_accept};
  wire [USF_EVT_W-1:0] evt_clr = wr_evt ? pwdata[USF_EVT_W-1:0] : '0;

  // extra bit reads zero while parity occupies it
  wire xrb_rd = extra_rx_bit_r & ~ctrl_r.parity_en; // R3

  wire [31:0] flags_word = {29'h0, xrb_rd, tx_done_q, rx_done_q};
  wire [31:0] rd_word    = sel_ctrl  ? {28'h0, ctrl_r} :
                           sel_flags ? flags_word :
                           sel_evt   ? {29'h0, evt_q} :
                           sel_mask  ? {29'h0, mask_r} : 32'h0;

  wire irq_nxt = (ctrl_r.irq_en & (rx_done_q | tx_done_q)) | (|(evt_q & mask_r)); // R5

  // apb answer sequencing: one wait state per transfer
  always_comb begin
    case (st_r)
      USF_IDLE: st_nxt = acc ? USF_ANS : USF_IDLE;
      USF_ANS:  st_nxt = USF_IDLE;
      default:  st_nxt = USF_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= USF_IDLE;
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      pready_r  <= (st_nxt == USF_ANS);
      prdata_r  <= (st_nxt == USF_ANS && !pwrite) ? rd_word : 32'h0;
      pslverr_r <= (st_nxt == USF_ANS) & ~hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= USF_CTRL_RST;
      mask_r <= USF_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[3:0];
      end
      if (wr_mask) begin
        mask_r <= pwdata[USF_EVT_W-1:0];
      end
    end
  end

  // extra receive bit follows every received frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extra_rx_bit_r <= 1'b0;
    end else if (rx_evt.valid) begin
      extra_rx_bit_r <= xrb_nxt; // R1 R2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // receive done: clear refused while FIFO still holds bytes
  usf_flag u_rx_done (
    .clk   (pclk),
    .rst_n (presetn),
    .set   (rx_accept),       // R7 R10
    .clr   (rx_clr),          // R6 R9
    .hold  (rx_fifo_pending), // R8
    .q     (rx_done_q)
  );

  usf_flag u_tx_done (
    .clk   (pclk),
    .rst_n (presetn),
    .set   (tx_stop_start), // R4
    .clr   (tx_clr),        // R6
    .hold  (1'b0),
    .q     (tx_done_q)
  );

  usf_w1c #(
    .W (USF_EVT_W)
  ) u_evt (
    .clk   (pclk),
    .rst_n (presetn),
    .set   (evt_set),
    .clr   (evt_clr),
    .q     (evt_q)
  );

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign extra_bit_enable = ctrl_r.extra_bit_enable;
  assign multiproc_enable = ctrl_r.multiproc_enable;
  assign parity_enable    = ctrl_r.parity_en;
  assign irq              = irq_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_XRB_EXTRA: assert property ( // R1
    rx_evt.valid && ctrl_r.extra_bit_enable |=> extra_rx_bit_r == $past(rx_evt.extra_bit))
    else $error("extra receive bit missed the extra bit");

  AST_XRB_STOP: assert property ( // R2
    rx_evt.valid && !ctrl_r.extra_bit_enable |=> extra_rx_bit_r == $past(rx_evt.stop_bit))
    else $error("extra receive bit missed the stop bit");

  AST_XRB_PARITY: assert property ( // R3
    acc && !pready_r && !pwrite && sel_flags && ctrl_r.parity_en |=> !prdata_r[USF_FLG_XRB])
    else $error("extra receive bit visible under parity");

  AST_TX_SET: assert property ( // R4
    tx_stop_start |=> tx_done_q ##1 (tx_done_q || $past(tx_clr)))
    else $error("transmit done not set at stop start");

  AST_IRQ: assert property ( // R5
    ctrl_r.irq_en && (rx_done_q || tx_done_q) |=> irq)
    else $error("interrupt not raised for done flag");

  AST_NO_SELF_CLR: assert property ( // R6
    tx_done_q && !tx_clr |=> tx_done_q)
    else $error("transmit done cleared without software");

  AST_RX_SET: assert property ( // R7
    rx_evt.valid && rx_evt.stop_bit && !ctrl_r.multiproc_enable |=> rx_done_q)
    else $error("receive done not set at stop sampling");

  AST_RX_HOLD: assert property ( // R8
    rx_done_q && rx_fifo_pending |=> rx_done_q)
    else $error("receive done dropped with bytes queued");

  AST_RX_CLR: assert property ( // R9
    rx_done_q && rx_clr && !rx_fifo_pending && !rx_accept |=> !rx_done_q)
    else $error("receive done clear refused after drain");

  AST_MP_BLOCK: assert property ( // R10
    !rx_done_q && rx_evt.valid && ctrl_r.multiproc_enable && !rx_evt.extra_bit |=> !rx_done_q)
    else $error("receive done set without extra bit in multiproc mode");

  AST_APB_WAIT: assert property (
    acc && !pready_r |=> pready_r ##1 !pready_r)
    else $error("apb answer not one wait state");

  AST_PREADY_PULSE: assert property (
    pready_r |=> !pready_r)
    else $error("apb ready stood longer than one cycle");

  AST_PRDATA_IDLE: assert property (
    !pready_r |-> prdata_r == 32'h0)
    else $error("read data not zero outside answer");

  AST_SLVERR_READY: assert property (
    pslverr_r |-> pready_r)
    else $error("slave error without ready");

  AST_SLVERR_UNMAPPED: assert property (
    acc && !pready_r && !hit |=> pslverr_r)
    else $error("unmapped address not flagged");

  AST_READ_DATA: assert property (
    acc && !pready_r && !pwrite |=> prdata_r == $past(rd_word))
    else $error("read data not the selected register");

  AST_WR_UNMAPPED: assert property (
    wr && !hit |=> $stable(ctrl_r) && $stable(mask_r))
    else $error("unmapped write changed a register");

  AST_CTRL_WRITE: assert property (
    wr_ctrl |=> {28'h0, ctrl_r} == ($past(pwdata) & 32'h0000000F))
    else $error("control write not taken");

  AST_CTRL_HOLD: assert property (
    !wr_ctrl |=> $stable(ctrl_r))
    else $error("control changed without a write");

  AST_MASK_WRITE: assert property (
    wr_mask |=> {29'h0, mask_r} == ($past(pwdata) & 32'h00000007))
    else $error("mask write not taken");

  AST_TX_SET_WINS: assert property ( // R4
    tx_stop_start && tx_clr |=> tx_done_q)
    else $error("transmit done lost to a coinciding clear");

  AST_TX_ONLY_STOP: assert property ( // R4
    !tx_done_q && !tx_stop_start |=> !tx_done_q)
    else $error("transmit done set without stop start");

  AST_TX_CLR: assert property ( // R6
    tx_done_q && tx_clr && !tx_stop_start |=> !tx_done_q)
    else $error("transmit done ignored software clear");

  AST_RX_NO_SELF_CLR: assert property ( // R6
    rx_done_q && !rx_clr |=> rx_done_q)
    else $error("receive done cleared without software");

  AST_RX_ONLY_ACCEPT: assert property ( // R7
    !rx_done_q && !rx_accept |=> !rx_done_q)
    else $error("receive done set without an accepted frame");

  AST_XRB_HOLD: assert property ( // R1
    !rx_evt.valid |=> $stable(extra_rx_bit_r))
    else $error("extra receive bit changed without a frame");

  AST_IRQ_LOW: assert property ( // R5
    !ctrl_r.irq_en && !(|(evt_q & mask_r)) |=> !irq_r)
    else $error("interrupt raised while disabled");

  AST_IRQ_EVT: assert property (
    (|(evt_q & mask_r)) |=> irq_r)
    else $error("interrupt missing for unmasked event");

  AST_EVT_REJ: assert property ( // R10
    rx_reject |=> evt_q[USF_EVT_REJ])
    else $error("rejected frame not recorded");

  AST_EVT_RX: assert property ( // R7
    rx_accept |=> evt_q[USF_EVT_RX])
    else $error("accepted frame not recorded");

  AST_EVT_CLR: assert property (
    wr_evt && pwdata[USF_EVT_TX] && !tx_stop_start |=> !evt_q[USF_EVT_TX])
    else $error("event bit ignored write of one");

  COV_RX_ACCEPT: cover property (rx_accept ##1 rx_done_q);
  COV_MP_REJECT: cover property (rx_reject && ctrl_r.multiproc_enable);
  COV_HELD_CLR:  cover property (rx_done_q && rx_clr && rx_fifo_pending ##1 rx_done_q);
  COV_IRQ:       cover property ($rose(irq));

endmodule // usf_top

// ==== rtl/usf_pkg.sv ====
/*
  usf_pkg: register map, field positions, reset values and carrier types
  for the serial port status and extra-bit flag block.
  Assumes a 32-bit APB register bus and a receive/transmit core on pclk.
*/
// Behaviour
// R1 - extra bit enabled: capture received extra bit
// R2 - extra bit disabled: capture first stop bit
// R3 - parity on: extra receive bit not valid
// R4 - set tx done when stop bit begins
// R5 - enabled interrupt raised by either done flag
// R6 - hardware never clears done flags itself
// R7 - set rx done at stop bit sampling
// R8 - rx done held while FIFO holds bytes
// R9 - clear succeeds only after FIFO drained
// R10 - multiproc mode needs stop and extra bit
package usf_pkg;

  localparam int USF_AW = 12;

  // register byte offsets
  localparam logic [USF_AW-1:0] USF_OFS_CTRL  = 12'h000;
  localparam logic [USF_AW-1:0] USF_OFS_FLAGS = 12'h004;
  localparam logic [USF_AW-1:0] USF_OFS_EVT   = 12'h008;
  localparam logic [USF_AW-1:0] USF_OFS_MASK  = 12'h00C;

  // control register fields
  localparam int USF_CTRL_XBE = 0;
  localparam int USF_CTRL_MPE = 1;
  localparam int USF_CTRL_PAR = 2;
  localparam int USF_CTRL_IE  = 3;

  // flag register fields
  localparam int USF_FLG_RX  = 0;
  localparam int USF_FLG_TX  = 1;
  localparam int USF_FLG_XRB = 2;

  // event status and mask fields
  localparam int USF_EVT_RX  = 0;
  localparam int USF_EVT_TX  = 1;
  localparam int USF_EVT_REJ = 2;
  localparam int USF_EVT_W   = 3;

  // reset values
  localparam logic [3:0]          USF_CTRL_RST = 4'h0;
  localparam logic [USF_EVT_W-1:0] USF_MASK_RST = 3'h0;

  typedef struct packed {
    logic irq_en;
    logic parity_en;
    logic multiproc_enable;
    logic extra_bit_enable;
  } usf_ctrl_s;

  // one received frame, reported at stop bit sampling
  typedef struct packed {
    logic valid;
    logic stop_bit;
    logic extra_bit;
  } usf_rx_evt_s;

  typedef enum logic [1:0] {
    USF_IDLE = 2'b01,
    USF_ANS  = 2'b10
  } usf_apb_e;

endpackage

// ==== rtl/usf_flag.sv ====
/*
  usf_flag: one sticky done flag.
  Assumes set, clr and hold come from logic on the same clock.
*/
`timescale 1ns/1ns
module usf_flag (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic set,
  input  wire logic clr,
  input  wire logic hold,
  // state
  output logic      q
);

  wire q_nxt = set | (q & ~(clr & ~hold));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else begin
      q <= q_nxt;
    end
  end

endmodule // usf_flag

// ==== rtl/usf_w1c.sv ====
/*
  usf_w1c: vector of sticky event bits, write-one-to-clear.
  Assumes set and clear vectors on the same clock; set wins.
*/
`timescale 1ns/1ns
module usf_w1c #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // control
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // state
  output logic      [W-1:0] q
);

  wire [W-1:0] q_nxt = set | (q & ~clr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= q_nxt;
    end
  end

endmodule // usf_w1c

// ==== tb/usf_core_model.sv ====
/*
  usf_core_model: stand-in for the receive/transmit core and its FIFO.
  Assumes pclk comes from the bench and that the bench calls the tasks.
*/
`timescale 1ns/1ns
module usf_core_model
  import usf_pkg::*;
(
  // clock
  input  wire logic   pclk,
  // core side
  output usf_rx_evt_s rx_evt,
  output logic        tx_stop_start,
  output logic        rx_fifo_pending
);
  initial begin
    rx_evt          = '0;
    tx_stop_start   = 1'b0;
    rx_fifo_pending = 1'b0;
  end
  // one frame, reported at stop bit sampling
  task automatic frame(input logic s, input logic x);
    @(posedge pclk);
    rx_evt <= '{1'b1, s, x};
    @(posedge pclk);
    // qualifiers mean nothing outside the pulse
    rx_evt <= '{1'b0, ~s, ~x};
  endtask
  task automatic tx_stop();
    @(posedge pclk);
    tx_stop_start <= 1'b1;
    @(posedge pclk);
    tx_stop_start <= 1'b0;
  endtask
  task automatic pend(input logic p);
    @(posedge pclk);
    rx_fifo_pending <= p;
  endtask
endmodule // usf_core_model

// ==== tb/tb.sv ====
/*
  tb: register-level tests of the serial done flags over APB.
  Assumes usf_core_model drives the core side of the design.
*/
`timescale 1ns/1ns
module tb;
  import usf_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite;
  logic [USF_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr, irq;
  logic              xbe, mpe, par;
  usf_rx_evt_s       rx_evt;
  logic              tx_ss, pend;
  int                failures, total_checks;
  localparam logic [USF_AW-1:0] C = USF_OFS_CTRL, F = USF_OFS_FLAGS;
  localparam logic [USF_AW-1:0] E = USF_OFS_EVT, M = USF_OFS_MASK;

  usf_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_evt(rx_evt), .tx_stop_start(tx_ss),
    .rx_fifo_pending(pend), .extra_bit_enable(xbe), .multiproc_enable(mpe),
    .parity_enable(par), .irq(irq));
  usf_core_model u_core (.pclk(pclk), .rx_evt(rx_evt), .tx_stop_start(tx_ss),
    .rx_fifo_pending(pend));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [USF_AW-1:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      chk("pready", 1, 0);
  endtask

  task automatic wr(input logic [USF_AW-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
    chk("wr err", 0, e);
  endtask

  task automatic rd(input logic [USF_AW-1:0] a, input logic [31:0] x, input logic xe = 1'b0);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk("rdata", x, r);
    chk("rd err", xe, e);
  endtask

  task automatic irq_is(input logic x);
    repeat (2) @(posedge pclk);
    chk("irq", x, irq);
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    end_of_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    failures = 0;
    total_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(C, 32'h0);
    rd(F, 32'h0);
    rd(E, 32'h0);
    rd(M, 32'h0);
    rd(12'h010, 32'h0, 1'b1);
    wr(C, 32'h1);
    @(posedge pclk);
    chk("xbe", 1, xbe);
    u_core.frame(1'b1, 1'b1);
    rd(F, 32'h5);
    u_core.frame(1'b0, 1'b0);
    rd(F, 32'h1);
    wr(F, 32'h0);
    wr(C, 32'h0);
    u_core.frame(1'b1, 1'b0);
    rd(F, 32'h5);
    wr(F, 32'h0);
    wr(C, 32'h4);
    @(posedge pclk);
    chk("par", 1, par);
    u_core.frame(1'b1, 1'b1);
    rd(F, 32'h1);
    wr(F, 32'h0);
    u_core.tx_stop();
    rd(F, 32'h2);
    wr(F, 32'h3);
    repeat (20) @(posedge pclk);
    rd(F, 32'h2);
    wr(F, 32'h0);
    rd(F, 32'h0);
    u_core.pend(1'b1);
    u_core.frame(1'b1, 1'b0);
    wr(F, 32'h0);
    rd(F, 32'h1);
    u_core.pend(1'b0);
    wr(F, 32'h0);
    rd(F, 32'h0);
    wr(E, 32'h7);
    rd(E, 32'h0);
    wr(C, 32'h3);
    @(posedge pclk);
    chk("mpe", 1, mpe);
    u_core.frame(1'b1, 1'b0);
    rd(F, 32'h0);
    rd(E, 32'h4);
    u_core.frame(1'b1, 1'b1);
    rd(F, 32'h5);
    irq_is(1'b0);
    wr(C, 32'hB);
    irq_is(1'b1);
    wr(F, 32'h0);
    irq_is(1'b0);
    wr(C, 32'h3);
    wr(M, 32'h2);
    rd(M, 32'h2);
    u_core.tx_stop();
    irq_is(1'b1);
    wr(E, 32'h2);
    irq_is(1'b0);
    end_of_test();
  end
endmodule // tb
